// ==== hdl/dtd_pkg.sv ====
`default_nettype none
package dtd_pkg;

    // Instruction groups in bits 15:12
    localparam logic [3:0] DTD_GRP_ABS8_LD = 4'h2;
    localparam logic [3:0] DTD_GRP_ABS8_ST = 4'h3;
    localparam logic [3:0] DTD_GRP_MOV = 4'h6;
    localparam logic [3:0] DTD_GRP_IMM8 = 4'hF;

    // Move-family mode field in bits 11:9
    localparam logic [2:0] DTD_M_REG = 3'h0;
    localparam logic [2:0] DTD_M_IND = 3'h1;
    localparam logic [2:0] DTD_M_DISP = 3'h2;
    localparam logic [2:0] DTD_M_PREPOST = 3'h3;
    localparam logic [2:0] DTD_M_ABS16 = 3'h4;
    localparam logic [2:0] DTD_M_IMM16 = 3'h5;
    localparam logic [2:0] DTD_M_PERIPH = 3'h6;
    localparam logic [2:0] DTD_M_PUSHPOP = 3'h7;

    // Field positions
    localparam int DTD_SIZE_BIT = 8;
    localparam int DTD_DIR_BIT = 7;

    // Direction field values
    localparam logic DTD_DIR_LOAD = 1'b0;
    localparam logic DTD_DIR_STORE = 1'b1;

    localparam logic [2:0] DTD_SP_IDX = 3'h7;
    localparam logic [15:0] DTD_PC_RESET = 16'h0000;
    localparam logic [15:0] DTD_PC_STEP = 16'h0002;
    localparam logic [15:0] DTD_STEP_WORD = 16'h0002;
    localparam logic [15:0] DTD_STEP_BYTE = 16'h0001;
    localparam logic [7:0] DTD_ABS8_PAGE = 8'hFF;
    localparam int DTD_E_DIV_DEF = 8;

    typedef enum logic [6:0] {
        S_IDLE = 7'h01,
        S_FETCH1 = 7'h02,
        S_FETCH2 = 7'h04,
        S_EXEC = 7'h08,
        S_MEM = 7'h10,
        S_PWAIT = 7'h20,
        S_PXFER = 7'h40
    } dtd_state_e;

endpackage
`default_nettype wire

// ==== hdl/dtd_eclk.sv ====
`timescale 1ns/1ns
`default_nettype none
module dtd_eclk import dtd_pkg::*; #(
    parameter int DIV = DTD_E_DIV_DEF
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    output logic o_tick,
    output logic o_e_clk
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;
    logic [CW-1:0] cnt_d;
    logic tick_q;
    logic tick_d;
    logic e_q;
    logic e_d;

    always_comb begin
        tick_d = (cnt_q == CW'(DIV - 1));
        cnt_d = tick_d ? '0 : cnt_q + 1'b1;
        e_d = (cnt_d >= CW'(DIV / 2));
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
            e_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
            e_q <= e_d;
        end
    end

    assign o_tick = tick_q;
    assign o_e_clk = e_q;
endmodule // dtd_eclk
`default_nettype wire

// ==== hdl/dtd_core.sv ====
`timescale 1ns/1ns
`default_nettype none
module dtd_core import dtd_pkg::*; #(
    parameter int E_DIV = DTD_E_DIV_DEF
) (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    output logic o_fetch_req,
    output logic [15:0] o_fetch_addr,
    input wire logic i_fetch_valid,
    input wire logic [15:0] i_fetch_word,
    output logic o_mem_req,
    output logic o_per_req,
    output logic o_mem_we,
    output logic o_mem_word,
    output logic [15:0] o_mem_addr,
    output logic [15:0] o_mem_wdata,
    input wire logic i_mem_ack,
    input wire logic [15:0] i_mem_rdata,
    output logic o_e_clk,
    output logic o_done,
    output logic o_illegal,
    input wire logic [2:0] i_dbg_sel,
    output logic [15:0] o_dbg_data
);
    dtd_state_e st_q, st_d;
    logic [15:0] regs_q [8];
    logic [15:0] regs_d [8];
    logic [15:0] pc_q, pc_d, ir_q, ir_d, ext_q, ext_d;
    logic [15:0] addr_q, addr_d, wdata_q, wdata_d, dbg_q, dbg_d;
    logic we_q, we_d, word_q, word_d, done_q, done_d, ill_q, ill_d;
    logic tick;

    logic [3:0] grp;
    logic [2:0] mode;
    logic dir;
    logic [2:0] rm;
    logic [3:0] rnf;
    logic [2:0] rn;
    logic is_mov, is_word;
    logic [2:0] areg;
    logic [15:0] step, ea;
    logic [7:0] src_byte;

    function automatic logic f_ext(input logic [15:0] w);
        logic [2:0] m;
        m = w[11:9];
        f_ext = (w[15:12] == DTD_GRP_MOV) && ((m == DTD_M_DISP) || (m == DTD_M_ABS16) ||
                (m == DTD_M_IMM16) || (m == DTD_M_PERIPH));
    endfunction

    function automatic logic [7:0] f_get(input logic [15:0] r, input logic lo);
        f_get = lo ? r[7:0] : r[15:8];
    endfunction

    function automatic logic [15:0] f_put(input logic [15:0] r, input logic lo,
                                          input logic [7:0] b);
        f_put = lo ? {r[15:8], b} : {b, r[7:0]};
    endfunction

    dtd_eclk #(.DIV(E_DIV)) u_eclk (
        .i_clk(i_clk),
        .i_rstn(i_rstn),
        .o_tick(tick),
        .o_e_clk(o_e_clk)
    );

    // Field extraction
    always_comb begin
        grp = ir_q[15:12];
        mode = ir_q[11:9];
        dir = ir_q[DTD_DIR_BIT];
        rm = ir_q[6:4];
        is_mov = (grp == DTD_GRP_MOV);
        rnf = is_mov ? ir_q[3:0] : ir_q[11:8];
        rn = rnf[2:0];
        areg = (mode == DTD_M_PUSHPOP) ? DTD_SP_IDX : rm;
        // Stack traffic is word wide whatever the size bit says
        is_word = is_mov && (ir_q[DTD_SIZE_BIT] || (mode == DTD_M_PUSHPOP) ||
                  ((mode == DTD_M_PREPOST) && (rm == DTD_SP_IDX)));
        step = is_word ? DTD_STEP_WORD : DTD_STEP_BYTE;
        src_byte = f_get(regs_q[rn], rnf[3]);
        case (mode)
            DTD_M_DISP: ea = regs_q[rm] + ext_q;
            DTD_M_ABS16, DTD_M_PERIPH: ea = ext_q;
            DTD_M_PREPOST, DTD_M_PUSHPOP: ea = dir ? regs_q[areg] - step : regs_q[areg];
            default: ea = regs_q[rm];
        endcase
    end

    always_comb begin
        st_d = st_q;
        pc_d = pc_q;
        ir_d = ir_q;
        ext_d = ext_q;
        addr_d = addr_q;
        wdata_d = wdata_q;
        we_d = we_q;
        word_d = word_q;
        done_d = 1'b0;
        ill_d = 1'b0;
        regs_d = regs_q;
        dbg_d = regs_q[i_dbg_sel];
        case (st_q)
            S_IDLE: begin
                if (i_run) begin
                    st_d = S_FETCH1;
                end
            end
            S_FETCH1: begin
                if (i_fetch_valid) begin
                    ir_d = i_fetch_word;
                    pc_d = pc_q + DTD_PC_STEP;
                    st_d = f_ext(i_fetch_word) ? S_FETCH2 : S_EXEC;
                end
            end
            S_FETCH2: begin
                if (i_fetch_valid) begin
                    ext_d = i_fetch_word;
                    pc_d = pc_q + DTD_PC_STEP;
                    st_d = S_EXEC;
                end
            end
            S_EXEC: begin
                st_d = i_run ? S_FETCH1 : S_IDLE;
                done_d = 1'b1;
                word_d = is_word;
                we_d = dir;
                wdata_d = is_word ? regs_q[rn] : {src_byte, src_byte};
                if (is_mov) begin
                    case (mode)
                        DTD_M_REG: begin
                            if (ir_q[DTD_SIZE_BIT]) begin
                                regs_d[rn] = regs_q[ir_q[6:4]];
                            end else begin
                                regs_d[rn] = f_put(regs_q[rn], rnf[3],
                                                   f_get(regs_q[ir_q[6:4]], ir_q[7]));
                            end
                        end
                        DTD_M_IMM16: begin
                            regs_d[rn] = is_word ? ext_q : f_put(regs_q[rn], rnf[3], ext_q[7:0]);
                        end
                        DTD_M_PERIPH: begin
                            // Byte transfer waits for the slow clock
                            addr_d = ea;
                            word_d = 1'b0;
                            we_d = dir;
                            wdata_d = {src_byte, src_byte};
                            st_d = S_PWAIT;
                            done_d = 1'b0;
                        end
                        default: begin
                            addr_d = is_word ? {ea[15:1], 1'b0} : ea;
                            if (mode == DTD_M_PREPOST || mode == DTD_M_PUSHPOP) begin
                                regs_d[areg] = dir ? regs_q[areg] - step
                                                   : regs_q[areg] + step;
                            end
                            st_d = S_MEM;
                            done_d = 1'b0;
                        end
                    endcase
                end else if (grp == DTD_GRP_IMM8) begin
                    regs_d[rn] = f_put(regs_q[rn], rnf[3], ir_q[7:0]);
                end else if (grp == DTD_GRP_ABS8_LD || grp == DTD_GRP_ABS8_ST) begin
                    addr_d = {DTD_ABS8_PAGE, ir_q[7:0]};
                    word_d = 1'b0;
                    we_d = (grp == DTD_GRP_ABS8_ST);
                    st_d = S_MEM;
                    done_d = 1'b0;
                end else begin
                    done_d = 1'b0;
                    ill_d = 1'b1;
                end
            end
            S_MEM: begin
                if (i_mem_ack) begin
                    if (!we_q) begin
                        regs_d[rn] = word_q ? i_mem_rdata
                                            : f_put(regs_q[rn], rnf[3], i_mem_rdata[7:0]);
                    end
                    done_d = 1'b1;
                    st_d = i_run ? S_FETCH1 : S_IDLE;
                end
            end
            S_PWAIT: begin
                if (tick) begin
                    st_d = S_PXFER;
                end
            end
            S_PXFER: begin
                if (tick) begin
                    if (we_q == DTD_DIR_LOAD) begin
                        regs_d[rn] = f_put(regs_q[rn], rnf[3], i_mem_rdata[7:0]);
                    end
                    done_d = 1'b1;
                    st_d = i_run ? S_FETCH1 : S_IDLE;
                end
            end
            default: st_d = S_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            st_q <= S_IDLE;
            regs_q <= '{default: 16'h0000};
            pc_q <= DTD_PC_RESET;
            ir_q <= 16'h0000;
            ext_q <= 16'h0000;
            addr_q <= 16'h0000;
            wdata_q <= 16'h0000;
            we_q <= 1'b0;
            word_q <= 1'b0;
            done_q <= 1'b0;
            ill_q <= 1'b0;
            dbg_q <= 16'h0000;
        end else begin
            st_q <= st_d;
            regs_q <= regs_d;
            pc_q <= pc_d;
            ir_q <= ir_d;
            ext_q <= ext_d;
            addr_q <= addr_d;
            wdata_q <= wdata_d;
            we_q <= we_d;
            word_q <= word_d;
            done_q <= done_d;
            ill_q <= ill_d;
            dbg_q <= dbg_d;
        end
    end

    assign o_fetch_req = (st_q == S_FETCH1) || (st_q == S_FETCH2);
    assign o_fetch_addr = pc_q;
    assign o_mem_req = (st_q == S_MEM);
    assign o_per_req = (st_q == S_PXFER);
    assign o_mem_we = we_q;
    assign o_mem_word = word_q;
    assign o_mem_addr = addr_q;
    assign o_mem_wdata = wdata_q;
    assign o_done = done_q;
    assign o_illegal = ill_q;
    assign o_dbg_data = dbg_q;

    AST_WORD_EVEN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (o_mem_req && o_mem_word) |-> !o_mem_addr[0])
        else $error("word access at odd address");
    AST_STACK_WORD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && is_mov && mode == DTD_M_PUSHPOP) |=> (o_mem_req && o_mem_word))
        else $error("stack access not word sized");
    AST_PUSH_DEC: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && is_mov && mode == DTD_M_PUSHPOP && dir)
        |=> (regs_q[DTD_SP_IDX] == $past(regs_q[DTD_SP_IDX]) - 16'h0002) && o_mem_we)
        else $error("push did not predecrement by two");
    AST_POP_INC: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && is_mov && mode == DTD_M_PUSHPOP && !dir)
        |=> (regs_q[DTD_SP_IDX] == $past(regs_q[DTD_SP_IDX]) + 16'h0002) && !o_mem_we)
        else $error("pop did not postincrement by two");
    AST_PER_START: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_per_req) |-> $past(tick))
        else $error("peripheral transfer not aligned to slow clock");
    AST_PER_LEN: assert property (@(posedge i_clk) disable iff (!i_rstn)
        $rose(o_per_req) |-> (o_per_req && !o_mem_word) [*2])
        else $error("peripheral transfer too short or not byte");
    AST_PER_DIR: assert property (@(posedge i_clk) disable iff (!i_rstn)
        o_per_req |-> (o_mem_we == ir_q[DTD_DIR_BIT]))
        else $error("peripheral direction mismatch");
    AST_EXT_FETCH: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && f_ext(ir_q)) |-> $past(st_q) == S_FETCH2)
        else $error("extension word not fetched");
    AST_IMM16: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && is_mov && mode == DTD_M_IMM16 && is_word)
        |=> regs_q[$past(rn)] == $past(ext_q))
        else $error("immediate word not loaded");
    AST_RR_WORD: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && is_mov && mode == DTD_M_REG && ir_q[DTD_SIZE_BIT])
        |=> regs_q[$past(rn)] == $past(regs_q[ir_q[6:4]]))
        else $error("register move wrong");
    AST_SHORT_BYTE: assert property (@(posedge i_clk) disable iff (!i_rstn)
        (st_q == S_EXEC && (grp == DTD_GRP_ABS8_LD || grp == DTD_GRP_ABS8_ST))
        |=> o_mem_req && !o_mem_word)
        else $error("short absolute access not byte");
endmodule // dtd_core
`default_nettype wire

// ==== verif/dtd_mem_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module dtd_mem_model (
    input wire logic i_clk,
    input wire logic i_slow,
    input wire logic i_fetch_req,
    input wire logic [15:0] i_fetch_addr,
    output logic o_fetch_valid,
    output logic [15:0] o_fetch_word,
    input wire logic i_mem_req,
    input wire logic i_per_req,
    input wire logic i_mem_we,
    input wire logic i_mem_word,
    input wire logic [15:0] i_mem_addr,
    input wire logic [15:0] i_mem_wdata,
    output logic o_mem_ack,
    output logic [15:0] o_mem_rdata
);
    logic [15:0] imem [0:255];
    logic [7:0] dmem [0:65535];
    int fw = 0;
    int mw = 0;
    initial begin
        o_fetch_valid = 1'b0;
        o_fetch_word = 16'h0000;
        o_mem_ack = 1'b0;
        o_mem_rdata = 16'h0000;
        for (int i = 0; i < 65536; i++) dmem[i] = 8'h00;
    end
    // Data lines toggle whenever nothing valid is offered
    always @(posedge i_clk) begin
        o_fetch_valid <= 1'b0;
        o_fetch_word <= ~o_fetch_word;
        o_mem_ack <= 1'b0;
        o_mem_rdata <= ~o_mem_rdata;
        if (i_fetch_req && !o_fetch_valid) begin
            if (fw > 0) fw <= fw - 1;
            else begin
                o_fetch_valid <= 1'b1;
                o_fetch_word <= imem[i_fetch_addr[8:1]];
                fw <= i_slow ? 2 : 0;
            end
        end
        if (i_mem_req && !o_mem_ack) begin
            if (mw > 0) mw <= mw - 1;
            else begin
                o_mem_ack <= 1'b1;
                mw <= i_slow ? 3 : 0;
                if (i_mem_we && i_mem_word) begin
                    dmem[i_mem_addr] <= i_mem_wdata[15:8];
                    dmem[i_mem_addr | 16'h0001] <= i_mem_wdata[7:0];
                end else if (i_mem_we) dmem[i_mem_addr] <= i_mem_wdata[7:0];
                else if (i_mem_word) begin
                    o_mem_rdata <= {dmem[i_mem_addr], dmem[i_mem_addr | 16'h0001]};
                end else o_mem_rdata <= {~dmem[i_mem_addr], dmem[i_mem_addr]};
            end
        end else if (i_per_req) begin
            o_mem_rdata <= {~dmem[i_mem_addr], dmem[i_mem_addr]};
            if (i_mem_we) dmem[i_mem_addr] <= i_mem_wdata[7:0];
        end
    end
endmodule // dtd_mem_model
`default_nettype wire

// ==== verif/tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int E = 4;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_run = 1'b0;
    logic slow_q = 1'b0;
    logic [2:0] i_dbg_sel = 3'h0;
    logic o_fetch_req, fv, o_mem_req, o_per_req, o_mem_we, o_mem_word, ack;
    logic o_e_clk, o_done, o_illegal;
    logic [15:0] o_fetch_addr, fword, o_mem_addr, o_mem_wdata, rdata, o_dbg_data;
    int failures = 0;
    int checks = 0;
    int seed = 32'hc0c8;
    int mr[8];
    int md[int];
    logic [15:0] prog[$];
    int exp_ill, exp_per, got_ill, got_per, plen, got_done, ehi;
    always #4 i_clk = ~i_clk;
    dtd_core #(.E_DIV(E)) dut_u (.i_clk(i_clk), .i_rstn(i_rstn), .i_run(i_run),
        .o_fetch_req(o_fetch_req), .o_fetch_addr(o_fetch_addr), .i_fetch_valid(fv),
        .i_fetch_word(fword), .o_mem_req(o_mem_req), .o_per_req(o_per_req),
        .o_mem_we(o_mem_we), .o_mem_word(o_mem_word), .o_mem_addr(o_mem_addr),
        .o_mem_wdata(o_mem_wdata), .i_mem_ack(ack), .i_mem_rdata(rdata), .o_e_clk(o_e_clk),
        .o_done(o_done), .o_illegal(o_illegal), .i_dbg_sel(i_dbg_sel), .o_dbg_data(o_dbg_data));
    dtd_mem_model mem_u (.i_clk(i_clk), .i_slow(slow_q), .i_fetch_req(o_fetch_req),
        .i_fetch_addr(o_fetch_addr), .o_fetch_valid(fv), .o_fetch_word(fword),
        .i_mem_req(o_mem_req), .i_per_req(o_per_req), .i_mem_we(o_mem_we),
        .i_mem_word(o_mem_word), .i_mem_addr(o_mem_addr), .i_mem_wdata(o_mem_wdata),
        .o_mem_ack(ack), .o_mem_rdata(rdata));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    function automatic int getr(logic [3:0] f, bit wd);
        if (wd) return mr[f[2:0]];
        return f[3] ? mr[f[2:0]] & 255 : mr[f[2:0]] >> 8;
    endfunction
    function automatic void setr(logic [3:0] f, bit wd, int v);
        if (wd) mr[f[2:0]] = v & 65535;
        else if (f[3]) mr[f[2:0]] = (mr[f[2:0]] & 65280) | (v & 255);
        else mr[f[2:0]] = (mr[f[2:0]] & 255) | ((v & 255) << 8);
    endfunction
    function automatic int rb(int a);
        return md.exists(a) ? md[a] : 0;
    endfunction
    function automatic int rd(int a, bit wd);
        return wd ? (rb(a & 65534) << 8) | rb(a | 1) : rb(a);
    endfunction
    function automatic void wr(int a, bit wd, int v);
        if (wd) md[a & 65534] = v >> 8;
        if (wd) md[a | 1] = v & 255;
        else md[a] = v & 255;
    endfunction
    function automatic void exec(logic [15:0] w, logic [15:0] x);
        logic [2:0] m;
        logic [2:0] a;
        bit wd;
        bit pp;
        int ad;
        m = w[11:9];
        a = w[6:4];
        wd = w[8];
        pp = m == 3 || m == 7;
        if (w[15:12] == 4'h2) setr(w[11:8], 0, rd(16'hFF00 | w[7:0], 0));
        else if (w[15:12] == 4'h3) wr(16'hFF00 | w[7:0], 0, getr(w[11:8], 0));
        else if (w[15:12] == 4'hF) setr(w[11:8], 0, w[7:0]);
        else if (m == 0) setr(w[3:0], wd, getr(w[7:4], wd));
        else if (m == 5) setr(w[3:0], wd, x);
        else begin
            if (m == 7) a = 3'h7;
            if (m == 7 || (m == 3 && a == 7)) wd = 1;
            if (m == 6) exp_per++;
            ad = (m == 2) ? mr[a] + x : (m == 4 || m == 6) ? x : mr[a];
            if (pp && w[7]) mr[a] = (mr[a] - wd - 1) & 65535;
            if (pp && w[7]) ad = mr[a];
            if (w[7]) wr(ad & 65535, wd, getr(w[3:0], wd));
            else setr(w[3:0], wd, rd(ad & 65535, wd));
            if (pp && !w[7]) mr[a] = (mr[a] + wd + 1) & 65535;
        end
    endfunction
    task automatic gen(input int reps);
        logic [15:0] w;
        logic [15:0] x;
        for (int r = 0; r < reps; r++) begin
            for (int k = 0; k < 12; k++) begin
                w = 16'($random(seed));
                x = 16'($random(seed));
                if (k < 8) w[15:9] = {4'h6, 3'(k)};
                else w[15:12] = k == 8 ? 4'h2 : k == 9 ? 4'h3 : k == 10 ? 4'hF : 4'h1;
                if (k == 5) w[7] = 1'b0;
                if (k == 6) w[8] = 1'b0;
                if (k == 7 || (k == 3 && w[6:4] == 3'h7)) w[8] = 1'b1;
                if (k == 7) w[6:4] = 3'h7;
                if ((k == 3 || k == 7) && w[2:0] == w[6:4]) w[2:0] = w[2:0] + 3'h1;
                prog.push_back(w);
                if (k == 2 || k == 4 || k == 5 || k == 6) prog.push_back(x);
                if (k == 11) exp_ill++;
                else exec(w, x);
            end
        end
    endtask
    // Bus monitor for word alignment and slow-clock transfer length
    always @(negedge i_clk) begin
        if (i_rstn) begin
            if (o_illegal === 1'b1) got_ill++;
            if (o_done === 1'b1) got_done++;
            if (o_mem_req === 1'b1 && o_mem_word === 1'b1) chk(o_mem_addr[0], 0);
            if (o_per_req === 1'b1) begin
                plen++;
                if (o_e_clk === 1'b1) ehi++;
                chk({o_mem_req, o_mem_word}, 0);
            end else if (plen > 0) begin
                chk(plen, E);
                chk(ehi, E / 2);
                got_per++;
                plen = 0;
                ehi = 0;
            end
        end
    end
    task automatic run(input bit slow, input int reps);
        int n;
        n = 0;
        foreach (mr[i]) mr[i] = 0;
        prog.delete();
        exp_ill = 0;
        exp_per = 0;
        gen(reps);
        for (int i = 0; i < 256; i++) mem_u.imem[i] = i < prog.size() ? prog[i] : 16'h6100;
        @(posedge i_clk);
        i_rstn <= 1'b0;
        i_run <= 1'b0;
        slow_q <= slow;
        repeat (20) @(posedge i_clk);
        @(negedge i_clk);
        chk({o_fetch_req, o_mem_req, o_per_req, o_done, o_illegal, o_e_clk}, 0);
        got_ill = 0;
        got_per = 0;
        got_done = 0;
        plen = 0;
        ehi = 0;
        @(posedge i_clk);
        i_rstn <= 1'b1;
        i_run <= 1'b1;
        while (n < 20000 && !(o_fetch_req === 1'b1 && o_fetch_addr === 16'(2 * prog.size()))) begin
            @(negedge i_clk);
            n++;
        end
        if (n >= 20000) begin
            failures++;
            $display("test timed out, slow %0d", slow);
            return;
        end
        @(posedge i_clk);
        i_run <= 1'b0;
        repeat (40) @(posedge i_clk);
        for (int i = 0; i < 8; i++) begin
            @(posedge i_clk);
            i_dbg_sel <= 3'(i);
            @(posedge i_clk);
            @(negedge i_clk);
            chk(o_dbg_data, mr[i]);
        end
        foreach (md[k]) chk(mem_u.dmem[k], md[k]);
        chk(got_ill, exp_ill);
        chk(got_done, 11 * reps + 1);
        chk(got_per, exp_per);
        $display("test done, slow %0d, words %0d", slow, prog.size());
    endtask
    initial begin
        run(1'b0, 8);
        run(1'b1, 8);
        end_sim();
    end
endmodule // tb_top
`default_nettype wire
